/* File: core/nemc_decode.sv */
`timescale 1ns/10ps
`include "nemc_regs.svh"

module nemc_decode #(
  parameter logic [5:0] SPACE0_BASE = `NEMC_SPACE0_BASE,
  parameter logic [5:0] SPACE1_BASE = `NEMC_SPACE1_BASE,
  parameter logic [5:0] SPACE2_BASE = `NEMC_SPACE2_BASE,
  parameter logic [5:0] SPACE3_BASE = `NEMC_SPACE3_BASE
) (
  input  wire logic [31:0] word_addr,
  input  wire logic        byte_off,
  input  wire logic        size_half,
  input  wire logic        width_16,
  output logic      [3:0]  space_hit,
  output logic      [1:0]  lane_hit
);

  logic [23:0] bases;

  assign bases = {SPACE3_BASE, SPACE2_BASE, SPACE1_BASE, SPACE0_BASE};

  // lane decode; an 8-bit memory uses lane 0 alone and no address bit
  function automatic logic [1:0] lanes_of(input logic off, input logic half,
                                          input logic w16);
    if (!w16) begin
      lanes_of = 2'h1;
    end else if (half) begin
      lanes_of = 2'h3;
    end else begin
      lanes_of = off ? 2'h2 : 2'h1;
    end
  endfunction : lanes_of

  // first match wins so two overlapping bases still give one select
  always_comb begin
    space_hit = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (space_hit == 4'h0 &&
          word_addr[`NEMC_SPACE_MSB:`NEMC_SPACE_LSB] == bases[i*6 +: 6]) begin
        space_hit[i] = 1'b1; // [RL1] [RL2]
      end
    end
  end

  assign lane_hit = lanes_of(byte_off, size_half, width_16); // [RL3]

endmodule : nemc_decode

/* File: core/nemc_pkg.sv */
package nemc_pkg;

  typedef enum logic [1:0] {
    NEMC_ST_IDLE    = 2'b00,
    NEMC_ST_ACCESS  = 2'b01,
    NEMC_ST_RELEASE = 2'b10,
    NEMC_ST_HOLD    = 2'b11
  } nemc_state_t;

  typedef enum logic [1:0] {
    NEMC_SRC_EXT  = 2'b00,
    NEMC_SRC_CPU4 = 2'b01,
    NEMC_SRC_CPU6 = 2'b10
  } nemc_src_t;

  typedef enum logic {
    NEMC_SIZE_BYTE = 1'b0,
    NEMC_SIZE_HALF = 1'b1
  } nemc_size_t;

endpackage : nemc_pkg

/* File: core/nemc_port_ctrl.sv */
`timescale 1ns/10ps
`include "nemc_regs.svh"

// What this block does
// RL1: at most one space select active per access, all others inactive
// RL2: space select chosen from word address bits 26 to 31
// RL3: byte lanes decoded from low address bits, count set by memory width
// RL4: byte lanes act as byte write enables, only addressed bytes written
// RL5: byte lanes double as sdram data masks on reads and writes
// RL6: direct transfer output lets two peripherals move data past the device
// RL7: an outside host asks for the bus by raising hold request
// RL8: hold grant answers a hold request once the bus is handed over
// RL9: bus need output shows a pending access while the bus is away
// RL10: port clock source fixed at reset from two strap pins
// RL11: divided output clock is port clock over 1, 2 or 4
// RL12: full output clock runs exactly at the port clock
// RL13: finish access, release outputs, then grant until request drops
module nemc_port_ctrl #(
  parameter logic [3:0] ACC_CYCLES  = `NEMC_ACC_CYCLES,
  parameter logic [5:0] SPACE0_BASE = `NEMC_SPACE0_BASE,
  parameter logic [5:0] SPACE1_BASE = `NEMC_SPACE1_BASE,
  parameter logic [5:0] SPACE2_BASE = `NEMC_SPACE2_BASE,
  parameter logic [5:0] SPACE3_BASE = `NEMC_SPACE3_BASE
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [1:0]  clock_source_strap_pins,
  input  wire logic        port_ext_input_clock,
  input  wire logic [1:0]  clk_div_sel,
  input  wire logic        mem_width_16,
  input  wire logic        acc_req,
  input  wire logic        acc_write,
  input  wire logic        acc_direct,
  input  wire logic        acc_size_half,
  input  wire logic [31:0] acc_word_addr,
  input  wire logic        acc_byte_off,
  input  wire logic        bus_hold_request,
  output logic             acc_ready,
  output logic             acc_done,
  output logic             acc_unmapped,
  output logic             space_select_0_n,
  output logic             space_select_1_n,
  output logic             space_select_2_n,
  output logic             space_select_3_n,
  output logic             byte_lane_enable_0_n,
  output logic             byte_lane_enable_1_n,
  output logic             peripheral_direct_transfer_n,
  output logic             mem_write_n,
  output logic             mem_read_n,
  output logic             port_out_en,
  output logic             bus_hold_grant,
  output logic             bus_need_out,
  output logic             port_clock_out_full,
  output logic             port_clock_out_divided,
  output logic [1:0]       clock_source
);

  nemc_pkg::nemc_state_t state_reg;
  nemc_pkg::nemc_state_t state_next;

  logic [3:0] cnt_reg;
  logic [3:0] space_hit;
  logic [1:0] lane_hit;
  logic [3:0] sel_n_reg;
  logic [1:0] lane_n_reg;
  logic       strap_done_reg;
  logic       toggle_en;
  logic       full_reg;
  logic       div_reg;
  logic       div_cnt_reg;
  logic       take;
  logic       last;

  nemc_decode #(
    .SPACE0_BASE (SPACE0_BASE),
    .SPACE1_BASE (SPACE1_BASE),
    .SPACE2_BASE (SPACE2_BASE),
    .SPACE3_BASE (SPACE3_BASE)
  ) u_decode (
    .word_addr (acc_word_addr),
    .byte_off  (acc_byte_off),
    .size_half (acc_size_half),
    .width_16  (mem_width_16),
    .space_hit (space_hit),
    .lane_hit  (lane_hit)
  );

  nemc_src_tick u_tick (
    .clk       (clk),
    .arst_n    (arst_n),
    .run       (strap_done_reg),
    .src       (clock_source),
    .ext_clk   (port_ext_input_clock),
    .cur_level (full_reg),
    .toggle_en (toggle_en)
  );

  // one-shot flag; the port clocks stay parked until the strap has been caught
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_done_reg <= 1'b0;
    end else begin
      strap_done_reg <= 1'b1;
    end
  end

  // strap caught on the first edge after release, then held until next reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clock_source <= nemc_pkg::NEMC_SRC_EXT;
    end else if (!strap_done_reg) begin
      if (clock_source_strap_pins == `NEMC_STRAP_CPU4) begin
        clock_source <= nemc_pkg::NEMC_SRC_CPU4; // [RL10]
      end else if (clock_source_strap_pins == `NEMC_STRAP_CPU6) begin
        clock_source <= nemc_pkg::NEMC_SRC_CPU6; // [RL10]
      end else begin
        clock_source <= nemc_pkg::NEMC_SRC_EXT; // [RL10]
      end
    end
  end

  // full clock toggles on each source half period, no division
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      full_reg <= 1'b0;
    end else if (toggle_en) begin
      full_reg <= ~full_reg; // [RL12]
    end
  end

  // counts full clock rises; the divide by four moves on every second one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_reg <= 1'b0;
    end else if (toggle_en && !full_reg && clk_div_sel != `NEMC_DIV_1) begin
      div_cnt_reg <= ~div_cnt_reg;
    end
  end

  // divided clock moves only on full clock edges so both stay phase aligned
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= 1'b0;
    end else if (toggle_en) begin
      if (clk_div_sel == `NEMC_DIV_1) begin
        div_reg <= ~full_reg; // [RL11]
      end else if (!full_reg) begin
        if (clk_div_sel == `NEMC_DIV_2 || div_cnt_reg) begin
          div_reg <= ~div_reg; // [RL11]
        end
      end
    end
  end

  assign port_clock_out_full    = full_reg;
  assign port_clock_out_divided = div_reg;

  // a waiting hold request beats a new access
  assign take = (state_reg == nemc_pkg::NEMC_ST_IDLE) && !bus_hold_request && acc_req;
  assign last = (state_reg == nemc_pkg::NEMC_ST_ACCESS) && (cnt_reg == 4'h1);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      nemc_pkg::NEMC_ST_IDLE: begin
        if (bus_hold_request) begin
          state_next = nemc_pkg::NEMC_ST_RELEASE; // [RL7] [RL13]
        end else if (acc_req) begin
          state_next = nemc_pkg::NEMC_ST_ACCESS;
        end
      end
      nemc_pkg::NEMC_ST_ACCESS: begin
        // an access in flight always runs to its end
        if (cnt_reg == 4'h1) begin
          state_next = nemc_pkg::NEMC_ST_IDLE; // [RL13]
        end
      end
      nemc_pkg::NEMC_ST_RELEASE: begin
        if (bus_hold_request) begin
          state_next = nemc_pkg::NEMC_ST_HOLD; // [RL8]
        end else begin
          state_next = nemc_pkg::NEMC_ST_IDLE;
        end
      end
      nemc_pkg::NEMC_ST_HOLD: begin
        if (!bus_hold_request) begin
          state_next = nemc_pkg::NEMC_ST_IDLE; // [RL13]
        end
      end
      default: begin
        state_next = nemc_pkg::NEMC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= nemc_pkg::NEMC_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 4'h0;
    end else if (take) begin
      cnt_reg <= (ACC_CYCLES == 4'h0) ? 4'h1 : ACC_CYCLES;
    end else if (state_reg == nemc_pkg::NEMC_ST_ACCESS) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end

  // selects latched at the start and held for the whole access
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_n_reg <= `NEMC_SEL_IDLE_N;
    end else if (take) begin
      sel_n_reg <= ~space_hit; // [RL1] [RL2]
    end else if (last) begin
      sel_n_reg <= `NEMC_SEL_IDLE_N; // [RL1]
    end
  end

  // lanes latched once, so a changing offset cannot glitch them mid-access
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lane_n_reg <= `NEMC_LANE_IDLE_N;
    end else if (take) begin
      lane_n_reg <= ~lane_hit; // [RL3] [RL4] [RL5]
    end else if (last) begin
      lane_n_reg <= `NEMC_LANE_IDLE_N;
    end
  end

  assign space_select_0_n     = sel_n_reg[0];
  assign space_select_1_n     = sel_n_reg[1];
  assign space_select_2_n     = sel_n_reg[2];
  assign space_select_3_n     = sel_n_reg[3];
  assign byte_lane_enable_0_n = lane_n_reg[0];
  assign byte_lane_enable_1_n = lane_n_reg[1];

  // strobes; the lanes mask reads too, so one set serves as sdram masks
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_write_n                  <= 1'b1;
      mem_read_n                   <= 1'b1;
      peripheral_direct_transfer_n <= 1'b1;
    end else if (take) begin
      mem_write_n                  <= ~acc_write; // [RL4]
      mem_read_n                   <= acc_write; // [RL5]
      peripheral_direct_transfer_n <= ~acc_direct; // [RL6]
    end else if (last) begin
      mem_write_n                  <= 1'b1;
      mem_read_n                   <= 1'b1;
      peripheral_direct_transfer_n <= 1'b1;
    end
  end

  // an unmapped access still runs its length so the requester sees its done
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_unmapped <= 1'b0;
    end else if (take) begin
      acc_unmapped <= (space_hit == 4'h0);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_done <= 1'b0;
    end else begin
      acc_done <= last;
    end
  end

  // drive enable falls a cycle before grant rises and returns as grant falls
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port_out_en <= 1'b1;
    end else begin
      port_out_en <= (state_next == nemc_pkg::NEMC_ST_IDLE) ||
                     (state_next == nemc_pkg::NEMC_ST_ACCESS); // [RL13]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_hold_grant <= 1'b0;
    end else begin
      bus_hold_grant <= (state_next == nemc_pkg::NEMC_ST_HOLD); // [RL8]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_need_out <= 1'b0;
    end else begin
      bus_need_out <= acc_req && ((state_next == nemc_pkg::NEMC_ST_RELEASE) ||
                                  (state_next == nemc_pkg::NEMC_ST_HOLD)); // [RL9]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_ready <= 1'b0;
    end else begin
      acc_ready <= (state_next == nemc_pkg::NEMC_ST_IDLE);
    end
  end

endmodule : nemc_port_ctrl

/* File: core/nemc_regs.svh */
`ifndef NEMC_REGS_SVH
`define NEMC_REGS_SVH

// clock source strap codes
`define NEMC_STRAP_EXT       2'h0
`define NEMC_STRAP_CPU4      2'h1
`define NEMC_STRAP_CPU6      2'h2
`define NEMC_STRAP_RSVD      2'h3

// divided clock factor codes
`define NEMC_DIV_1           2'h0
`define NEMC_DIV_2           2'h1
`define NEMC_DIV_4           2'h2

// core clock half periods for the internal sources
`define NEMC_HALF_CPU4       2'h2
`define NEMC_HALF_CPU6       2'h3

// space select field of the word address
`define NEMC_SPACE_MSB       31
`define NEMC_SPACE_LSB       26
`define NEMC_SPACE_W         6

// default space bases
`define NEMC_SPACE0_BASE     6'h20
`define NEMC_SPACE1_BASE     6'h24
`define NEMC_SPACE2_BASE     6'h28
`define NEMC_SPACE3_BASE     6'h2c

// access length in core cycles
`define NEMC_ACC_CYCLES      4'h4

// reset values
`define NEMC_SEL_IDLE_N      4'hf
`define NEMC_LANE_IDLE_N     2'h3

`endif

/* File: core/nemc_src_tick.sv */
`timescale 1ns/10ps
`include "nemc_regs.svh"

module nemc_src_tick (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       run,
  input  wire logic [1:0] src,
  input  wire logic       ext_clk,
  input  wire logic       cur_level,
  output logic            toggle_en
);

  logic [1:0] cnt_reg;
  logic       ext_reg;
  logic [1:0] half;

  assign half = (src == nemc_pkg::NEMC_SRC_CPU6) ? `NEMC_HALF_CPU6 : `NEMC_HALF_CPU4;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_reg <= 1'b0;
    end else begin
      ext_reg <= ext_clk;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 2'h0;
    end else if (!run || toggle_en) begin
      cnt_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end

  // external source: follow the sampled pin, so edges lag by one core cycle
  always_comb begin
    if (!run) begin
      toggle_en = 1'b0;
    end else if (src == nemc_pkg::NEMC_SRC_EXT) begin
      toggle_en = (ext_reg != cur_level);
    end else begin
      toggle_en = (cnt_reg == half - 2'h1);
    end
  end

endmodule : nemc_src_tick

/* File: verification/narrow_ext_mem_port_control_tb.sv */
`timescale 1ns/10ps

module narrow_ext_mem_port_control_tb;
  logic        clk, arst_n, port_ext_input_clock, mem_width_16, acc_req, acc_write;
  logic        acc_direct, acc_size_half, acc_byte_off, bus_hold_request, want_bus;
  logic        acc_ready, acc_done, acc_unmapped, space_select_0_n, space_select_1_n;
  logic        space_select_2_n, space_select_3_n, byte_lane_enable_0_n, byte_lane_enable_1_n;
  logic        peripheral_direct_transfer_n, mem_write_n, mem_read_n, port_out_en;
  logic        bus_hold_grant, bus_need_out, port_clock_out_full, port_clock_out_divided;
  logic [1:0]  clock_source_strap_pins, clk_div_sel, clock_source;
  logic [31:0] acc_word_addr;
  int          mismatches, n_compared, cycles;
  wire logic [3:0] sel_n = {space_select_3_n, space_select_2_n,
                            space_select_1_n, space_select_0_n};
  wire logic [1:0] lane_n = {byte_lane_enable_1_n, byte_lane_enable_0_n};

  nemc_port_ctrl uut (.clk, .arst_n, .clock_source_strap_pins, .port_ext_input_clock,
    .clk_div_sel, .mem_width_16, .acc_req, .acc_write, .acc_direct, .acc_size_half,
    .acc_word_addr, .acc_byte_off, .bus_hold_request, .acc_ready, .acc_done, .acc_unmapped,
    .space_select_0_n, .space_select_1_n, .space_select_2_n, .space_select_3_n,
    .byte_lane_enable_0_n, .byte_lane_enable_1_n, .peripheral_direct_transfer_n,
    .mem_write_n, .mem_read_n, .port_out_en, .bus_hold_grant, .bus_need_out,
    .port_clock_out_full, .port_clock_out_divided, .clock_source);
  nemc_host_model host (.clk, .want_bus, .bus_hold_grant, .bus_hold_request,
    .port_ext_input_clock);

  always #50 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %0h, expected %0h", $time, got, exp);
      mismatches++;
    end
  endtask : check

  task automatic do_reset(input logic [1:0] s);
    arst_n = 1'b0;
    clock_source_strap_pins = s;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
  endtask : do_reset

  task automatic access(input logic [31:0] a, input logic wr, dir, half, off,
                        input logic [3:0] es, input logic [1:0] el);
    int n;
    n = 0;
    while (acc_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    {acc_word_addr, acc_write, acc_direct, acc_size_half, acc_byte_off} = {a, wr, dir, half, off};
    acc_req = 1'b1;
    @(negedge clk);
    acc_req = 1'b0;
    check(sel_n, es ^ 4'hf);
    check(acc_unmapped, es == 4'h0);
    if (es != 4'h0) begin
      check(lane_n, el ^ 2'h3);
      check({peripheral_direct_transfer_n, mem_write_n, mem_read_n}, {!dir, !wr, wr});
      repeat (4) @(negedge clk);
      check(acc_done, 1'b1);
    end
  endtask : access

  // a request left high is taken again in the done cycle
  task automatic t_b2b;
    acc_word_addr = {6'h24, 26'h0};
    acc_req = 1'b1;
    @(negedge clk);
    check(sel_n, 4'hd);
    repeat (4) @(negedge clk);
    check({acc_done, sel_n}, 5'h1f);
    @(negedge clk);
    acc_req = 1'b0;
    check({acc_done, sel_n}, 5'h0d);
    repeat (4) @(negedge clk);
  endtask : t_b2b

  // hold arrives mid-access and must wait for it, then beats a pending request
  task automatic t_hold;
    int n;
    n = 0;
    acc_word_addr = {6'h20, 26'h0};
    acc_req = 1'b1;
    want_bus <= 1'b1;
    while (bus_hold_grant !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check(n, 7);
    repeat (3) @(negedge clk);
    check({acc_ready, port_out_en, bus_need_out, sel_n}, 7'h1f);
    want_bus <= 1'b0;
    acc_req = 1'b0;
    repeat (2) @(negedge clk);
    check({bus_hold_grant, port_out_en, bus_need_out}, 3'h2);
  endtask : t_hold

  task automatic period(input logic pick, output int p);
    logic cur, prev;
    int   k, rises;
    rises = 0;
    p = 0;
    prev = pick ? port_clock_out_divided : port_clock_out_full;
    for (k = 0; k < 400 && rises < 3; k++) begin
      @(negedge clk);
      cur = pick ? port_clock_out_divided : port_clock_out_full;
      p++;
      if (cur && !prev) begin
        rises++;
        if (rises < 3) p = 0;
      end
      prev = cur;
    end
  endtask : period

  task automatic t_clocks;
    int s, d, p, f;
    for (s = 0; s < 4; s++) begin
      do_reset(s[1:0]);
      check(clock_source, (s == 3) ? 0 : s);
      f = (s == 1) ? 4 : (s == 2) ? 6 : 16;
      for (d = 0; d < 4; d++) begin
        clk_div_sel = d[1:0];
        period(1'b0, p);
        check(p, f);
        period(1'b1, p);
        check(p, f * ((d == 0) ? 1 : (d == 1) ? 2 : 4));
      end
    end
  endtask : t_clocks

  initial begin
    {clk, arst_n, acc_req, acc_write, acc_direct, acc_size_half, acc_byte_off, want_bus} = '0;
    {clock_source_strap_pins, clk_div_sel, acc_word_addr} = '0;
    mem_width_16 = 1'b1;
    cycles = 0;
    mismatches = 0;
    n_compared = 0;
    @(negedge clk);
    do_reset(2'h1);
    access({6'h20, 26'h10}, 1'b0, 1'b0, 1'b1, 1'b0, 4'h1, 2'h3);
    access({6'h24, 26'h0}, 1'b1, 1'b0, 1'b0, 1'b0, 4'h2, 2'h1);
    access({6'h28, 26'h3}, 1'b1, 1'b1, 1'b0, 1'b1, 4'h4, 2'h2);
    access({6'h2c, 26'h0}, 1'b0, 1'b1, 1'b1, 1'b0, 4'h8, 2'h3);
    access({6'h2d, 26'h0}, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 2'h0);
    mem_width_16 = 1'b0;
    access({6'h20, 26'h0}, 1'b1, 1'b0, 1'b1, 1'b1, 4'h1, 2'h1);
    t_b2b();
    t_hold();
    t_clocks();
    conclude();
  end
endmodule : narrow_ext_mem_port_control_tb

/* File: verification/nemc_host_model.sv */
`timescale 1ns/10ps

module nemc_host_model (
  input  wire logic clk,
  input  wire logic want_bus,
  input  wire logic bus_hold_grant,
  output logic      bus_hold_request,
  output logic      port_ext_input_clock
);
  logic [2:0] ext_cnt_reg;

  initial begin
    bus_hold_request = 1'b0;
    port_ext_input_clock = 1'b0;
    ext_cnt_reg = 3'h0;
  end

  // once asked, the host waits for the grant before it may let go
  always @(negedge clk) begin
    bus_hold_request <= want_bus || (bus_hold_request && !bus_hold_grant);
  end

  // free running board clock, slow against the core clock
  always @(negedge clk) begin
    ext_cnt_reg <= ext_cnt_reg + 3'h1;
    if (ext_cnt_reg == 3'h7) begin
      port_ext_input_clock <= !port_ext_input_clock;
    end
  end
endmodule : nemc_host_model

/* File: verification/nemc_port_ctrl_monitor.sv */
`timescale 1ns/10ps
`include "nemc_regs.svh"

module nemc_port_ctrl_monitor (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        mem_width_16,
  input wire logic        acc_req,
  input wire logic        acc_write,
  input wire logic        acc_direct,
  input wire logic        acc_size_half,
  input wire logic [31:0] acc_word_addr,
  input wire logic        acc_byte_off,
  input wire logic        bus_hold_request,
  input wire logic        acc_ready,
  input wire logic        acc_done,
  input wire logic        space_select_0_n,
  input wire logic        space_select_1_n,
  input wire logic        space_select_2_n,
  input wire logic        space_select_3_n,
  input wire logic        byte_lane_enable_0_n,
  input wire logic        byte_lane_enable_1_n,
  input wire logic        peripheral_direct_transfer_n,
  input wire logic        mem_write_n,
  input wire logic        mem_read_n,
  input wire logic        port_out_en,
  input wire logic        bus_hold_grant,
  input wire logic        bus_need_out,
  input wire logic        port_clock_out_full,
  input wire logic [1:0]  clock_source
);
  logic [3:0] sel_n;
  logic [3:0] hit;
  logic [1:0] lane_n;
  logic [1:0] lane;
  logic [5:0] field;

  assign sel_n = {space_select_3_n, space_select_2_n, space_select_1_n, space_select_0_n};
  assign lane_n = {byte_lane_enable_1_n, byte_lane_enable_0_n};
  assign field = acc_word_addr[`NEMC_SPACE_MSB:`NEMC_SPACE_LSB];
  assign hit = {field == `NEMC_SPACE3_BASE, field == `NEMC_SPACE2_BASE,
                field == `NEMC_SPACE1_BASE, field == `NEMC_SPACE0_BASE};
  assign lane = !mem_width_16 ? 2'h1 : acc_size_half ? 2'h3 : {acc_byte_off, !acc_byte_off};

  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_take;
    acc_ready && acc_req && !bus_hold_request;
  endsequence
  // unmapped accesses run their strobes with no select, so only hits are judged
  sequence s_hit;
    s_take ##0 (hit != 4'h0);
  endsequence
  sequence s_strobes;
    (mem_write_n != mem_read_n) [*4] ##1 (mem_write_n && mem_read_n && acc_done);
  endsequence

  AST_ONE_SEL: assert property ($onehot0(~sel_n))
    else $error("two space selects low together");
  AST_SPACE: assert property (s_take |=> sel_n == ~$past(hit))
    else $error("space select does not follow address");
  AST_LANES: assert property (s_hit |=> lane_n == ~$past(lane))
    else $error("byte lanes wrong for access");
  AST_STROBES: assert property (s_hit |=> s_strobes)
    else $error("access strobes of wrong length");
  AST_DIRECT: assert property (s_hit |=> peripheral_direct_transfer_n == !$past(acc_direct)
    && mem_write_n == !$past(acc_write))
    else $error("direct or write strobe wrong");
  AST_GRANT_SAFE: assert property (bus_hold_grant |-> !port_out_en)
    else $error("grant while port still driven");
  AST_GRANT_BOUND: assert property (bus_hold_request [*8] |=> bus_hold_grant)
    else $error("hold request not granted in time");
  AST_GRANT_DROP: assert property ($fell(bus_hold_request) && bus_hold_grant
    |=> !bus_hold_grant && port_out_en)
    else $error("grant not withdrawn after request fell");
  AST_NEED: assert property ($past(acc_req) && !$past(port_out_en) && !port_out_en
    |-> bus_need_out)
    else $error("bus need missing while bus away");
  AST_FULL_CPU4: assert property (clock_source == nemc_pkg::NEMC_SRC_CPU4
    && $changed(port_clock_out_full) |=> $stable(port_clock_out_full)
    ##1 $changed(port_clock_out_full))
    else $error("full clock not at core over four");
endmodule : nemc_port_ctrl_monitor

bind nemc_port_ctrl nemc_port_ctrl_monitor u_mon (.clk, .arst_n, .mem_width_16, .acc_req,
  .acc_write, .acc_direct, .acc_size_half, .acc_word_addr, .acc_byte_off, .bus_hold_request,
  .acc_ready, .acc_done, .space_select_0_n, .space_select_1_n, .space_select_2_n,
  .space_select_3_n, .byte_lane_enable_0_n, .byte_lane_enable_1_n,
  .peripheral_direct_transfer_n, .mem_write_n, .mem_read_n, .port_out_en, .bus_hold_grant,
  .bus_need_out, .port_clock_out_full, .clock_source);
